// file: bench/cpu_status_flags_bank_map_tb.sv
// Purpose: Self-checking bench for the flags register and bank map
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Operands from a fixed-seed shift register plus corners
`timescale 1ns/1ps
module cpu_status_flags_bank_map_tb;
	import flags_bank_pkg::*;
	logic        clk_sys_in, rst_in, wr, rd, valid;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata_out, ef, res, er;
	logic        psel;
	logic [5:0]  ctl;
	logic [6:0]  k;
	logic [15:0] lf, v;
	alu_req_t    req;
	alu_op_t     op;
	int          failures, total_checks;
	logic [15:0] cn [8] = '{16'h01FF, 16'h0100, 16'h0FF0, 16'h0080,
		16'h0001, 16'h0000, 16'h010F, 16'h5A5A};
	exec_model u_exec_model (.clk_in(clk_sys_in), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd), .valid_out(valid),
		.req_out(req), .ctl_out(ctl));
	cpu_status_flags_bank_map u_cpu_status_flags_bank_map (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(ctl[4]),
		.wdog_reset_in(ctl[3]), .watchdog_timeout_in(ctl[2]),
		.watchdog_clear_instr_in(ctl[1]), .sleep_instr_in(ctl[0]),
		.alu_valid_in(valid), .alu_req_in(req), .linear_in(ctl[5]),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata_out), .alu_result_out(res), .flags_out(),
		.region_out(), .periph_sel_out(psel));
	function automatic logic [7:0] rslt(input alu_op_t o,
		input logic [7:0] a, b, input logic c);
		case (o)
			OP_ADD: return a + b;
			OP_SUB: return a - b;
			OP_LOGIC: return a & b;
			OP_ROT_LEFT: return {a[6:0], c};
			OP_ROT_RIGHT: return {c, a[7:1]};
			default: return 8'h00;
		endcase
	endfunction : rslt
	function automatic logic [15:0] nx(input logic [15:0] l);
		return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
	endfunction : nx
	function automatic logic [7:0] calc(input alu_op_t o,
		input logic [7:0] a, b, f, input logic w);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] n;
		// Data write to the three bits lands only with no flag update
		n = (w && (o == OP_MOVE || o == OP_NONE)) ? {f[7:3], ~a[2:0]}
			: f;
		s = (o == OP_SUB) ? a + {1'b0, ~b} + 9'h001 : a + b;
		h = {1'b0, a[3:0]} + ((o == OP_SUB) ? {1'b0, ~b[3:0]} + 5'h01
			: {1'b0, b[3:0]});
		case (o)
			OP_ADD, OP_SUB: n[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
			OP_LOGIC: n[2] = (a & b) == 8'h00;
			OP_ROT_LEFT: n[0] = a[7];
			OP_ROT_RIGHT: n[0] = a[0];
			OP_CLEAR: n[2] = 1'b1;
			default: ;
		endcase
		return n;
	endfunction : calc
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rdchk(input logic [11:0] a, input logic l,
		input logic [7:0] e);
		u_exec_model.cyc(a, ~e, 2'b01, OP_NONE, 8'h00, 8'h00, {l, 5'h00});
		chk(rdata_out, e);
	endtask : rdchk
	task automatic evchk(input logic [4:0] e, input logic [1:0] tp);
		u_exec_model.cyc(12'h000, 8'h00, 2'b00, OP_NONE, 8'h00, 8'h00,
			{1'b0, e});
		ef[4:3] = tp;
		if (e[4]) ef = 8'h18;
		rdchk(12'h003, 1'b0, ef);
	endtask : evchk
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (3000) @(posedge clk_sys_in);
		failures++;
		finish_test();
	end
	initial begin
		failures = 0;
		total_checks = 0;
		lf = 16'h098A;
		ef = 8'h18;
		rst_in = 1'b1;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		rdchk(12'h003, 1'b0, ef);
		chk({7'h00, psel}, 8'h00);
		u_exec_model.cyc(12'h083, 8'hFF, 2'b10, OP_NONE, 8'h00, 8'h00, 6'h00);
		ef = 8'h1F;
		rdchk(12'h103, 1'b0, ef);
		for (int i = 0; i < 48; i++) begin
			lf = nx(lf);
			v = (i < 8) ? cn[i] : lf;
			op = alu_op_t'(4'(1 + i % 6));
			u_exec_model.cyc(12'h003, ~v[7:0], {i[1], 1'b0}, op, v[7:0],
				v[15:8], 6'h00);
			er = rslt(op, v[7:0], v[15:8], ef[0]);
			chk(res, er);
			ef = calc(op, v[7:0], v[15:8], ef, i[1]);
			rdchk(12'h003, 1'b0, ef);
		end
		evchk(5'h02, 2'b11);
		evchk(5'h04, 2'b01);
		evchk(5'h01, 2'b10);
		evchk(5'h10, 2'b11);
		u_exec_model.cyc(12'h09F, 8'h00, 2'b10, OP_NONE, 8'h00, 8'h00, 6'h00);
		chk({7'h00, psel}, 8'h01);
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			k = (i == 0) ? 7'd79 : 7'(lf[14:8] % 7'd80);
			u_exec_model.cyc({5'(i), 7'h20 + k}, lf[7:0], 2'b10, OP_NONE,
				8'h00, 8'h00, 6'h00);
			rdchk(12'(i * 80) + 12'(k), 1'b1, lf[7:0]);
			u_exec_model.cyc({5'(i), 7'h70 + k[3:0]}, ~lf[7:0], 2'b10,
				OP_NONE, 8'h00, 8'h00, 6'h00);
			rdchk({5'(7 - i), 7'h70 + k[3:0]}, 1'b0, ~lf[7:0]);
		end
		finish_test();
	end
endmodule : cpu_status_flags_bank_map_tb

// file: bench/exec_model.sv
// Purpose: Execute-side model driving bus, ALU and event lines
// Assumes: Requests change 1 ns after a rising edge
// Notes:   One call is one instruction cycle
`timescale 1ns/1ps
module exec_model (
	input  wire logic                clk_in,
	output logic [11:0]              addr_out,
	output logic [7:0]               wdata_out,
	output logic                     wr_out,
	output logic                     rd_out,
	output logic                     valid_out,
	output flags_bank_pkg::alu_req_t req_out,
	output logic [5:0]               ctl_out
);
	import flags_bank_pkg::*;
	// Every line set on each call, so back-to-back calls never glitch
	task automatic cyc(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] s, input alu_op_t op, input logic [7:0] x,
		input logic [7:0] y, input logic [5:0] c);
		addr_out <= a;
		wdata_out <= d;
		{wr_out, rd_out} <= s;
		valid_out <= op != OP_NONE;
		req_out <= {op, x, y, 1'b0};
		ctl_out <= c;
		@(posedge clk_in);
		#1;
	endtask : cyc
	initial cyc(12'h000, 8'h00, 2'b00, OP_NONE, 8'h00, 8'h00, 6'h00);
endmodule : exec_model

// file: bench/status_flags_properties.sv
// Purpose: Port relations of the flags register and bank map
// Assumes: Flags port lags the register by one cycle
// Notes:   Bound into the block
`timescale 1ns/1ps
module status_flags_checker (
	input wire logic                     clk_sys_in,
	input wire logic                     rst_in,
	input wire logic                     por_in,
	input wire logic                     wdog_reset_in,
	input wire logic                     watchdog_timeout_in,
	input wire logic                     watchdog_clear_instr_in,
	input wire logic                     sleep_instr_in,
	input wire logic                     alu_valid_in,
	input wire flags_bank_pkg::alu_req_t alu_req_in,
	input wire logic                     linear_in,
	input wire logic [11:0]              addr_in,
	input wire logic                     wr_in,
	input wire logic                     rd_in,
	input wire logic [7:0]               rdata_out,
	input wire logic [7:0]               flags_out,
	input wire flags_bank_pkg::region_t  region_out
);
	import flags_bank_pkg::*;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire ev = por_in | wdog_reset_in | watchdog_timeout_in;
	wire ins = watchdog_clear_instr_in | sleep_instr_in;
	wire op_ok = alu_valid_in && !ev;
	wire ad = op_ok && alu_req_in.op == OP_ADD;
	wire [8:0] sm = alu_req_in.a + alu_req_in.b;
	wire [4:0] nb = alu_req_in.a[3:0] + alu_req_in.b[3:0];
	wire [6:0] off = addr_in[6:0];
	wire fw = wr_in && off == 7'h03 && !linear_in;
	wire fr = rd_in && off == 7'h03 && !linear_in;
	upper_zero_a: assert property (flags_out[7:5] == 3'h0)
		else $error("flags upper bits not zero");
	flags_read_a: assert property (fr |=> rdata_out == flags_out)
		else $error("flags read differs");
	expiry_clr_a: assert property (
		watchdog_timeout_in && !por_in |-> ##2 !flags_out[4])
		else $error("expiry flag not cleared");
	clear_set_a: assert property (
		watchdog_clear_instr_in && !ev && !sleep_instr_in
		|-> ##2 flags_out[4:3] == 2'b11) else $error("clear wrong");
	ro_bits_a: assert property (
		fw && !ev && !ins |-> ##2 $stable(flags_out[4:3]))
		else $error("status bits written");
	add_flags_a: assert property (ad |-> ##2
		flags_out[2:0] == {$past(sm[7:0], 2) == 8'h00,
		$past(nb[4], 2), $past(sm[8], 2)}) else $error("add flags");
	rotate_carry_a: assert property (
		op_ok && alu_req_in.op == OP_ROT_RIGHT
		|-> ##2 flags_out[0] == $past(alu_req_in.a[0], 2))
		else $error("rotate carry wrong");
	clear_zero_a: assert property (
		op_ok && alu_req_in.op == OP_CLEAR |-> ##2 flags_out[2])
		else $error("clear left zero flag low");
	por_value_a: assert property (
		por_in |-> ##2 flags_out == 8'h18) else $error("por value");
	periph_map_a: assert property (!linear_in |->
		(region_out == REGION_PERIPH) == (off >= 7'h0C && off <= 7'h1F))
		else $error("peripheral decode wrong");
	cover property (ad && fw);
	cover property (por_in);
	cover property (linear_in && rd_in);
endmodule : status_flags_checker
bind cpu_status_flags_bank_map status_flags_checker u_status_flags_checker (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in),
	.wdog_reset_in(wdog_reset_in), .watchdog_timeout_in(watchdog_timeout_in),
	.watchdog_clear_instr_in(watchdog_clear_instr_in),
	.sleep_instr_in(sleep_instr_in), .alu_valid_in(alu_valid_in),
	.alu_req_in(alu_req_in), .linear_in(linear_in), .addr_in(addr_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.flags_out(flags_out), .region_out(region_out));

// file: src/bank_decoder.sv
// Purpose: Decode a banked data address into its region and RAM slot
// Assumes: Linear view is a flat index into the general RAM
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "flags_bank_cfg.svh"

module bank_decoder (
	input  wire logic [11:0]             addr_in,
	input  wire logic                    linear_in,
	output flags_bank_pkg::bank_dec_t    dec_out,
	output logic      [9:0]              ram_addr_out
);
	import flags_bank_pkg::*;

	logic [6:0] off;
	logic [4:0] bank;
	logic [11:0] lin_idx;

	assign off  = addr_in[6:0];
	assign bank = addr_in[11:7];
	assign lin_idx = addr_in - `LINEAR_BASE;

	always_comb begin
		dec_out      = '{region: REGION_NONE, ram_index: 7'h00, hit: 1'b0};
		ram_addr_out = 10'h000;
		if (linear_in) begin
			// Bank-independent view of all general RAM
			if (lin_idx < 12'(`RAM_BYTES_PER_BANK * `RAM_BANKS)) begin
				dec_out.region = REGION_RAM;
				dec_out.hit    = 1'b1;
				ram_addr_out   = lin_idx[9:0];
			end
		end else if (off <= `CORE_LAST) begin
			dec_out.region = REGION_CORE;
			dec_out.hit    = 1'b1;
		end else if (off <= `PERIPH_LAST) begin
			dec_out.region = REGION_PERIPH;
			dec_out.hit    = 1'b1;
		end else if (off <= `RAM_LAST) begin
			dec_out.ram_index = off - `RAM_FIRST;
			if (bank < 5'(`RAM_BANKS)) begin
				dec_out.region = REGION_RAM;
				dec_out.hit    = 1'b1;
				ram_addr_out   = 10'(bank) * 10'd80
					+ {3'b000, dec_out.ram_index};
			end
		end else begin
			// Same 16 bytes whatever the bank
			dec_out.region = REGION_COMMON;
			dec_out.hit    = 1'b1;
			ram_addr_out   = {6'h00, off[3:0]};
		end
	end

endmodule : bank_decoder

// file: src/cpu_status_flags_bank_map.sv
// Purpose: Arithmetic flags register and banked data memory for the core
// Assumes: One instruction per clock; strobes are one-cycle pulses
// Notes:   Unmapped addresses read as zero
//
// How it works
// - Bits 7 to 5 read zero, ignore writes
// - Expiry flag set by power-up, clear, sleep
// - Power-down flag set by power-up, clear; sleep clears
// - Both reset-status flags ignore register writes
// - Flag-updating op beats data write to flags
// - Zero flag follows all-zero result
// - Nibble carry from bit 3 on add/sub
// - Carry out of bit 7 on add/sub
// - Subtract adds two's complement; borrow active low
// - Rotates load carry from shifted-out bit
// - Clearing flags register gives 000u u1uu
// - Power-on sets 11 and zero arithmetic flags
// - Offsets 0Ch to 1Fh are peripheral registers
// - Up to 80 bytes general RAM per bank
// - Sixteen common bytes shared by every bank
// - General RAM linear through indirect pointer
`timescale 1ns/1ps
`include "flags_bank_cfg.svh"

module cpu_status_flags_bank_map (
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_in,
	input  wire logic                    por_in,
	input  wire logic                    wdog_reset_in,
	input  wire logic                    watchdog_timeout_in,
	input  wire logic                    watchdog_clear_instr_in,
	input  wire logic                    sleep_instr_in,
	input  wire logic                    alu_valid_in,
	input  wire flags_bank_pkg::alu_req_t alu_req_in,
	input  wire logic                    linear_in,
	input  wire logic [11:0]             addr_in,
	input  wire logic [7:0]              wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [7:0]              rdata_out,
	output logic      [7:0]              alu_result_out,
	output logic      [7:0]              flags_out,
	output flags_bank_pkg::region_t      region_out,
	output logic                         periph_sel_out
);
	import flags_bank_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Flag storage
	logic       watchdog_expiry_flag;
	logic       power_down_flag;
	logic       zero_flag;
	logic       nibble_carry_flag;
	logic       carry_flag;
	logic [7:0] cpu_arith_flags;

	////////////////////////////////////////////////////////////////////////
	// ALU
	logic [7:0] next_result;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opnd_b;
	logic       carry_in;
	logic       next_carry;
	logic       next_nibble;
	logic       upd_zero;
	logic       upd_carry;
	logic       upd_nibble;

	function automatic logic is_arith(input alu_op_t op);
		is_arith = (op == OP_ADD) || (op == OP_SUB);
	endfunction : is_arith

	always_comb begin
		// Subtract as add of two's complement
		// Carry-in of one keeps both borrow outputs right for any operand
		carry_in = (alu_req_in.op == OP_SUB);
		opnd_b = carry_in ? ~alu_req_in.b : alu_req_in.b;
		sum = {1'b0, alu_req_in.a} + {1'b0, opnd_b} + {8'h00, carry_in};
		nib = {1'b0, alu_req_in.a[3:0]} + {1'b0, opnd_b[3:0]}
			+ {4'h0, carry_in};
		next_result = 8'h00;
		next_carry  = carry_flag;
		next_nibble = nib[4];
		case (alu_req_in.op)
			OP_ADD, OP_SUB: begin
				next_result = sum[7:0];
				next_carry  = sum[8];
			end
			OP_LOGIC: begin
				next_result = alu_req_in.a & alu_req_in.b;
			end
			OP_ROT_LEFT: begin
				next_result = {alu_req_in.a[6:0], carry_flag};
				next_carry  = alu_req_in.a[7];
			end
			OP_ROT_RIGHT: begin
				next_result = {carry_flag, alu_req_in.a[7:1]};
				next_carry  = alu_req_in.a[0];
			end
			OP_MOVE: begin
				next_result = alu_req_in.a;
			end
			default: begin
				next_result = 8'h00;
			end
		endcase
		upd_zero   = alu_valid_in && (is_arith(alu_req_in.op)
			|| alu_req_in.op == OP_LOGIC || alu_req_in.op == OP_CLEAR);
		upd_nibble = alu_valid_in && is_arith(alu_req_in.op);
		upd_carry  = alu_valid_in && (is_arith(alu_req_in.op)
			|| alu_req_in.op == OP_ROT_LEFT
			|| alu_req_in.op == OP_ROT_RIGHT);
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			alu_result_out <= 8'h00;
		end else if (alu_valid_in) begin
			alu_result_out <= next_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flag write decode
	logic flags_wr;
	logic flags_wr_ok;
	logic flags_dest;

	assign flags_dest = !linear_in
		&& addr_in[6:0] == `REG_FLAGS_OFFSET;
	assign flags_wr = wr_in && flags_dest;
	// Any flag-updating op blocks the write to all three bits
	assign flags_wr_ok = flags_wr && !(upd_zero || upd_nibble || upd_carry);

	// Arithmetic flags: ALU beats a data write to the same bits
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			zero_flag         <= 1'b0;
			nibble_carry_flag <= 1'b0;
			carry_flag        <= 1'b0;
		end else if (por_in) begin
			zero_flag         <= 1'b0;
			nibble_carry_flag <= 1'b0;
			carry_flag        <= 1'b0;
		end else begin
			if (upd_zero) begin
				zero_flag <= (alu_req_in.op == OP_CLEAR)
					|| (next_result == 8'h00);
			end else if (flags_wr_ok) begin
				zero_flag <= wdata_in[`FLAG_ZERO_BIT];
			end
			if (upd_nibble) begin
				nibble_carry_flag <= next_nibble;
			end else if (flags_wr_ok) begin
				nibble_carry_flag <= wdata_in[`FLAG_NIBBLE_BIT];
			end
			if (upd_carry) begin
				carry_flag <= next_carry;
			end else if (flags_wr_ok) begin
				carry_flag <= wdata_in[`FLAG_CARRY_BIT];
			end
		end
	end

	// Reset-status flags: writes never reach them
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			watchdog_expiry_flag <= 1'b1;
			power_down_flag      <= 1'b1;
		end else if (por_in) begin
			watchdog_expiry_flag <= 1'b1;
			power_down_flag      <= 1'b1;
		end else if (watchdog_timeout_in || wdog_reset_in) begin
			// Timeout wins: it is the event being recorded
			watchdog_expiry_flag <= 1'b0;
		end else if (watchdog_clear_instr_in) begin
			watchdog_expiry_flag <= 1'b1;
			power_down_flag      <= 1'b1;
		end else if (sleep_instr_in) begin
			watchdog_expiry_flag <= 1'b1;
			power_down_flag      <= 1'b0;
		end
	end

	// Upper three bits held at zero
	assign cpu_arith_flags = {3'b000, watchdog_expiry_flag, power_down_flag,
		zero_flag, nibble_carry_flag, carry_flag} & `FLAGS_IMPL_MASK;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= `FLAGS_POR_VALUE;
		end else begin
			flags_out <= cpu_arith_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Banked memory
	bank_dec_t  dec;
	logic [9:0] ram_addr;
	logic [7:0] general_ram [`RAM_BYTES_PER_BANK * `RAM_BANKS];
	logic [7:0] common_ram  [`COMMON_BYTES];

	bank_decoder u_dec (
		.addr_in      (addr_in),
		.linear_in    (linear_in),
		.dec_out      (dec),
		.ram_addr_out (ram_addr)
	);

	assign region_out     = dec.region;
	assign periph_sel_out = (wr_in || rd_in) && dec.region == REGION_PERIPH;

	// No reset on RAM: contents are undefined after power-up
	always_ff @(posedge clk_sys_in) begin
		if (wr_in && dec.hit && dec.region == REGION_RAM) begin
			general_ram[ram_addr] <= wdata_in;
		end
		if (wr_in && dec.hit && dec.region == REGION_COMMON) begin
			common_ram[ram_addr[3:0]] <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			if (flags_dest) begin
				rdata_out <= cpu_arith_flags;
			end else if (dec.hit && dec.region == REGION_RAM) begin
				rdata_out <= general_ram[ram_addr];
			end else if (dec.hit && dec.region == REGION_COMMON) begin
				rdata_out <= common_ram[ram_addr[3:0]];
			end else begin
				rdata_out <= 8'h00;
			end
		end else begin
			rdata_out <= 8'h00;
		end
	end

endmodule : cpu_status_flags_bank_map

// file: src/flags_bank_cfg.svh
// Purpose: Constants for the arithmetic flags register and bank decode
// Assumes: 7-bit in-bank offsets, 12-bit data addresses
// Notes:   Offsets and sizes of the bank partition
`ifndef FLAGS_BANK_CFG_SVH
`define FLAGS_BANK_CFG_SVH

`define FLAG_CARRY_BIT      0
`define FLAG_NIBBLE_BIT     1
`define FLAG_ZERO_BIT       2
`define FLAG_PDOWN_BIT      3
`define FLAG_WDOG_BIT       4
`define FLAGS_IMPL_MASK     8'h1F
`define FLAGS_ARITH_MASK    8'h07
`define FLAGS_POR_VALUE     8'h18

`define REG_FLAGS_OFFSET    7'h03
`define REG_LINEAR_OFFSET   7'h7F
`define CORE_LAST           7'h0B
`define PERIPH_FIRST        7'h0C
`define PERIPH_LAST         7'h1F
`define RAM_FIRST           7'h20
`define RAM_LAST            7'h6F
`define COMMON_FIRST        7'h70
`define COMMON_LAST         7'h7F
`define RAM_BYTES_PER_BANK  80
`define RAM_BANKS           8
`define COMMON_BYTES        16
`define LINEAR_BASE         12'h000

`endif

// file: src/flags_bank_pkg.sv
// Purpose: Types shared by the flags register and bank decoder
// Assumes: Nothing beyond the cfg header
// Notes:   Region and operation kinds
package flags_bank_pkg;

	typedef enum logic [2:0] {
		REGION_CORE,
		REGION_PERIPH,
		REGION_RAM,
		REGION_COMMON,
		REGION_NONE
	} region_t;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD,
		OP_SUB,
		OP_LOGIC,
		OP_ROT_LEFT,
		OP_ROT_RIGHT,
		OP_CLEAR,
		OP_MOVE
	} alu_op_t;

	typedef struct packed {
		alu_op_t    op;
		logic [7:0] a;
		logic [7:0] b;
		logic       to_flags;
	} alu_req_t;

	typedef struct packed {
		region_t    region;
		logic [6:0] ram_index;
		logic       hit;
	} bank_dec_t;

endpackage : flags_bank_pkg
